// >>> rtl/nag_consts.svh
// register offsets, field positions, reset values, decimal adjustment figures and bus responses
// assumes inclusion by the nibble alu block files only
`ifndef NAG_CONSTS_SVH
`define NAG_CONSTS_SVH
// register byte offsets
`define NAG_OFF_POINTER 8'h00
`define NAG_OFF_STATUS 8'h04
`define NAG_OFF_INDEX 8'h08
`define NAG_OFF_MEMPTR 8'h0c
`define NAG_OFF_IRQ_STAT 8'h10
`define NAG_OFF_IRQ_CLR 8'h14
`define NAG_OFF_IRQ_EN 8'h18
// status word bit positions
`define NAG_ST_IXE 0
`define NAG_ST_Z 1
`define NAG_ST_CY 2
`define NAG_ST_CMP 3
`define NAG_ST_BCD 4
// memory row pointer enable position
`define NAG_MP_MPE 8
// event bit positions
`define NAG_EV_DONE 0
`define NAG_EV_SKIP 1
`define NAG_EV_CARRY 2
// reset values
`define NAG_RST_PTR 4'h0
`define NAG_RST_STATUS 5'h00
`define NAG_RST_INDEX 11'h000
`define NAG_RST_MEMPTR 7'h00
`define NAG_RST_IRQ 3'h0
// decimal adjustment figures
`define NAG_BCD_MAX 5'h09
`define NAG_BCD_FIX 4'h6
// bus responses
`define NAG_RESP_OKAY 2'h0
`define NAG_RESP_SLVERR 2'h2
`endif

// >>> rtl/nag_pkg.sv
// types shared by the nibble alu block
// assumes nothing beyond a systemverilog compiler
package nag_pkg;
    // decoded instruction; no register-with-immediate form exists
    typedef enum logic [4:0] {
        op_add, op_add_with_carry, op_sub, op_subtract_with_borrow,
        op_and, op_or, op_xor, op_load_register, op_store_register,
        op_set_imm, op_indirect_move, op_indirect_fetch,
        op_rotate_right_carry, op_skip_true, op_skip_false,
        op_skip_eq, op_skip_ne, op_skip_ge, op_skip_lt
    } nag_op_t;
    // instruction sequencer
    typedef enum logic [2:0] {
        st_idle, st_rd_r, st_latch, st_rd_m, st_exec, st_wb
    } nag_state_t;
endpackage : nag_pkg

// >>> rtl/nag_hold_reg.sv
// temporary operand holding register
// assumes one synchronous active-high reset
`timescale 1ns/1ps
module nag_hold_reg #(
    parameter int W = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] q_ff;
    // capture on load, hold otherwise
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            q_ff <= '0;
        end else if (load_i) begin
            q_ff <= d_i;
        end
    end
    assign q_o = q_ff;
endmodule : nag_hold_reg

// >>> rtl/nag_bcd_adder.sv
// 4-bit adder/subtractor with decimal adjustment
// assumes operands already held in registers
`timescale 1ns/1ps
`include "nag_consts.svh"
module nag_bcd_adder (
    input wire logic [3:0] a_i,
    input wire logic [3:0] b_i,
    input wire logic cin_i,
    input wire logic sub_i,
    input wire logic bcd_i,
    output logic [3:0] res_o,
    output logic cout_o
);
    logic [4:0] raw;
    // binary result, then decimal correction
    always_comb begin
        if (sub_i) begin
            raw = {1'b0, a_i} - {1'b0, b_i} - {4'h0, cin_i};
        end else begin
            raw = {1'b0, a_i} + {1'b0, b_i} + {4'h0, cin_i};
        end
        res_o = raw[3:0];
        cout_o = raw[4];
        if (bcd_i && !sub_i && raw > `NAG_BCD_MAX) begin
            res_o = raw[3:0] + `NAG_BCD_FIX;
            cout_o = 1'b1;
        end
        if (bcd_i && sub_i && raw[4]) begin
            res_o = raw[3:0] - `NAG_BCD_FIX;
        end
    end
endmodule : nag_bcd_adder

// >>> rtl/nag_alu_top.sv
// nibble alu datapath with general register addressing
// assumes a data memory that returns read data one cycle after dm_re_o
`timescale 1ns/1ps
`include "nag_consts.svh"
module nag_alu_top (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire nag_pkg::nag_op_t instr_op_i,
    input wire logic [3:0] instr_col_i,
    input wire logic [10:0] instr_mem_i,
    input wire logic [3:0] instr_imm_i,
    output logic instr_ready_o,
    output logic instr_done_o,
    output logic instr_skip_o,
    output logic [10:0] dm_addr_o,
    output logic dm_re_o,
    output logic dm_we_o,
    output logic [3:0] dm_wdata_o,
    input wire logic [3:0] dm_rdata_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic irq_o
);
    import nag_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    nag_state_t state_ff;
    nag_op_t op_ff;
    logic [3:0] col_ff, imm_ff, tmp_a, tmp_b, ptr_ff, wr_data, add_res;
    logic [10:0] mem_ff, index_ff, m_eff, wr_addr, greg_addr, awaddr_ff;
    logic [6:0] mp_ff;
    logic [4:0] status_ff, nxt_status;
    logic [2:0] irq_stat_ff, irq_en_ff, nxt_irq_stat, ev;
    logic [31:0] wdata_ff, wmask, m_ptr, m_st, m_idx, m_mp, m_en, rd_mux;
    logic [7:0] awaddr_q;
    logic ready_ff, done_ff, skip_ff, re_ff, we_ff, mpe_ff, irq_ff;
    logic is_arith, add_cout, wr_en, skip_c, hw_upd, rd_hit, wr_hit;
    logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff, awready_ff, wready_ff;
    logic arready_ff, nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid, wr_go;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [3:0] wstrb_ff;
    logic [10:0] dm_addr_ff;
    logic [3:0] dm_wdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // address formation
    // register row: live bank bit, 3-bit row, column from operand
    assign greg_addr = {3'h0, ptr_ff, col_ff};
    // index modification of the memory operand
    assign m_eff = status_ff[`NAG_ST_IXE] ? (mem_ff | index_ff) : mem_ff;
    // indirect target: operand bank/row (or row pointer), register column
    function automatic logic [10:0] ind_addr(input logic [3:0] col);
        ind_addr = {(mpe_ff ? mp_ff : m_eff[10:4]), col};
    endfunction : ind_addr

    ////////////////////////////////////////////////////////////////////////
    // temporary registers a (register nibble) and b (memory nibble)
    nag_hold_reg #(.W(4)) u_tmp_a (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .load_i(state_ff == st_latch), .d_i(dm_rdata_i), .q_o(tmp_a)
    );
    nag_hold_reg #(.W(4)) u_tmp_b (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .load_i(state_ff == st_exec), .d_i(dm_rdata_i), .q_o(tmp_b)
    );

    // arithmetic with optional decimal adjustment
    assign is_arith = op_ff inside {op_add, op_add_with_carry, op_sub, op_subtract_with_borrow};
    nag_bcd_adder u_add (
        .a_i(tmp_a), .b_i(tmp_b),
        .cin_i(status_ff[`NAG_ST_CY] && (op_ff inside {op_add_with_carry, op_subtract_with_borrow})),
        .sub_i(op_ff inside {op_sub, op_subtract_with_borrow}),
        .bcd_i(status_ff[`NAG_ST_BCD]),
        .res_o(add_res), .cout_o(add_cout)
    );

    ////////////////////////////////////////////////////////////////////////
    // result, destination and skip decision
    always_comb begin
        wr_en = 1'b0;
        wr_addr = greg_addr;
        wr_data = tmp_a;
        skip_c = 1'b0;
        case (op_ff)
            op_add, op_add_with_carry, op_sub, op_subtract_with_borrow: begin
                wr_en = !status_ff[`NAG_ST_CMP];
                wr_data = add_res;
            end
            op_and: begin wr_en = 1'b1; wr_data = tmp_a & tmp_b; end
            op_or: begin wr_en = 1'b1; wr_data = tmp_a | tmp_b; end
            op_xor: begin wr_en = 1'b1; wr_data = tmp_a ^ tmp_b; end
            op_load_register: begin wr_en = 1'b1; wr_data = tmp_b; end
            op_rotate_right_carry: begin
                wr_en = 1'b1;
                wr_data = {status_ff[`NAG_ST_CY], tmp_a[3:1]};
            end
            op_store_register: begin wr_en = 1'b1; wr_addr = m_eff; end
            op_set_imm: begin wr_en = 1'b1; wr_addr = m_eff; wr_data = imm_ff; end
            op_indirect_move: begin
                wr_en = 1'b1;
                wr_addr = ind_addr(tmp_a);
                wr_data = tmp_b;
            end
            op_indirect_fetch: begin wr_en = 1'b1; wr_addr = m_eff; wr_data = tmp_b; end
            op_skip_true: skip_c = (tmp_b & imm_ff) == imm_ff;
            op_skip_false: skip_c = (tmp_b & imm_ff) == 4'h0;
            op_skip_eq: skip_c = tmp_b == imm_ff;
            op_skip_ne: skip_c = tmp_b != imm_ff;
            op_skip_ge: skip_c = tmp_b >= imm_ff;
            op_skip_lt: skip_c = tmp_b < imm_ff;
            default: skip_c = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: read register, read operand, execute, write back
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_ff <= st_idle;
            ready_ff <= 1'b1;
            done_ff <= 1'b0;
            skip_ff <= 1'b0;
            re_ff <= 1'b0;
            we_ff <= 1'b0;
            dm_addr_ff <= 11'h000;
            dm_wdata_ff <= 4'h0;
            op_ff <= op_add;
            col_ff <= 4'h0;
            mem_ff <= 11'h000;
            imm_ff <= 4'h0;
        end else begin
            re_ff <= 1'b0;
            we_ff <= 1'b0;
            done_ff <= 1'b0;
            skip_ff <= 1'b0;
            case (state_ff)
                st_idle: begin
                    if (instr_valid_i) begin
                        op_ff <= instr_op_i;
                        col_ff <= instr_col_i;
                        mem_ff <= instr_mem_i;
                        imm_ff <= instr_imm_i;
                        // register row read like any memory nibble
                        dm_addr_ff <= {3'h0, ptr_ff, instr_col_i};
                        re_ff <= 1'b1;
                        ready_ff <= 1'b0;
                        state_ff <= st_rd_r;
                    end
                end
                st_rd_r: state_ff <= st_latch;
                st_latch: begin
                    dm_addr_ff <= (op_ff == op_indirect_fetch) ? ind_addr(dm_rdata_i) : m_eff;
                    re_ff <= 1'b1;
                    state_ff <= st_rd_m;
                end
                st_rd_m: state_ff <= st_exec;
                st_exec: state_ff <= st_wb;
                st_wb: begin
                    we_ff <= wr_en;
                    dm_addr_ff <= wr_addr;
                    dm_wdata_ff <= wr_data;
                    done_ff <= 1'b1;
                    skip_ff <= skip_c;
                    ready_ff <= 1'b1;
                    state_ff <= st_idle;
                end
                default: state_ff <= st_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status word: instruction update wins over a bus write
    assign hw_upd = (state_ff == st_wb) && (is_arith || op_ff == op_rotate_right_carry);
    always_comb begin
        nxt_status = status_ff;
        if (op_ff == op_rotate_right_carry) begin
            nxt_status[`NAG_ST_CY] = tmp_a[0];
        end else begin
            nxt_status[`NAG_ST_CY] = add_cout;
            if (status_ff[`NAG_ST_CMP]) begin
                nxt_status[`NAG_ST_Z] = status_ff[`NAG_ST_Z] && (add_res == 4'h0);
            end else begin
                nxt_status[`NAG_ST_Z] = add_res == 4'h0;
            end
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            status_ff <= `NAG_RST_STATUS;
        end else if (hw_upd) begin
            status_ff <= nxt_status;
        end else if (wr_go && awaddr_q == `NAG_OFF_STATUS) begin
            status_ff <= m_st[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers: pointer, index, row pointer, irq enable
    assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign m_ptr = ({28'h0, ptr_ff} & ~wmask) | (wdata_ff & wmask);
    assign m_st = ({27'h0, status_ff} & ~wmask) | (wdata_ff & wmask);
    assign m_idx = ({21'h0, index_ff} & ~wmask) | (wdata_ff & wmask);
    assign m_mp = ({23'h0, mpe_ff, 1'b0, mp_ff} & ~wmask) | (wdata_ff & wmask);
    assign m_en = ({29'h0, irq_en_ff} & ~wmask) | (wdata_ff & wmask);
    assign awaddr_q = awaddr_ff[7:0];
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ptr_ff <= `NAG_RST_PTR;
            index_ff <= `NAG_RST_INDEX;
            mp_ff <= `NAG_RST_MEMPTR;
            mpe_ff <= 1'b0;
            irq_en_ff <= `NAG_RST_IRQ;
        end else if (wr_go) begin
            case (awaddr_q)
                // bank bits above the lowest are not stored
                `NAG_OFF_POINTER: ptr_ff <= m_ptr[3:0];
                `NAG_OFF_INDEX: index_ff <= m_idx[10:0];
                `NAG_OFF_MEMPTR: begin
                    mp_ff <= m_mp[6:0];
                    mpe_ff <= m_mp[`NAG_MP_MPE];
                end
                `NAG_OFF_IRQ_EN: irq_en_ff <= m_en[2:0];
                default: ptr_ff <= ptr_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky events, set beats write-one clear
    assign ev[`NAG_EV_DONE] = state_ff == st_wb;
    assign ev[`NAG_EV_SKIP] = (state_ff == st_wb) && skip_c;
    assign ev[`NAG_EV_CARRY] = hw_upd && is_arith && add_cout;
    always_comb begin
        nxt_irq_stat = irq_stat_ff;
        if (wr_go && awaddr_q == `NAG_OFF_IRQ_CLR && wstrb_ff[0]) begin
            nxt_irq_stat = irq_stat_ff & ~wdata_ff[2:0];
        end
        nxt_irq_stat = nxt_irq_stat | ev;
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_stat_ff <= `NAG_RST_IRQ;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_ff <= |(nxt_irq_stat & irq_en_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_hit = awaddr_q inside {`NAG_OFF_POINTER, `NAG_OFF_STATUS, `NAG_OFF_INDEX,
        `NAG_OFF_MEMPTR, `NAG_OFF_IRQ_CLR, `NAG_OFF_IRQ_EN};
    assign nxt_aw_got = wr_go ? 1'b0 : (aw_got_ff || (s_axi_awvalid_i && awready_ff));
    assign nxt_w_got = wr_go ? 1'b0 : (w_got_ff || (s_axi_wvalid_i && wready_ff));
    assign nxt_bvalid = wr_go || (bvalid_ff && !s_axi_bready_i);
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bresp_ff <= `NAG_RESP_OKAY;
            awaddr_ff <= 11'h000;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            bvalid_ff <= nxt_bvalid;
            awready_ff <= !nxt_aw_got && !nxt_bvalid;
            wready_ff <= !nxt_w_got && !nxt_bvalid;
            if (s_axi_awvalid_i && awready_ff) begin
                awaddr_ff <= {3'h0, s_axi_awaddr_i};
            end
            if (s_axi_wvalid_i && wready_ff) begin
                wdata_ff <= s_axi_wdata_i;
                wstrb_ff <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                bresp_ff <= wr_hit ? `NAG_RESP_OKAY : `NAG_RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr_i)
            `NAG_OFF_POINTER: rd_mux = {28'h0, ptr_ff};
            `NAG_OFF_STATUS: rd_mux = {27'h0, status_ff};
            `NAG_OFF_INDEX: rd_mux = {21'h0, index_ff};
            `NAG_OFF_MEMPTR: rd_mux = {23'h0, mpe_ff, 1'b0, mp_ff};
            `NAG_OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_ff};
            `NAG_OFF_IRQ_CLR: rd_mux = 32'h0;
            `NAG_OFF_IRQ_EN: rd_mux = {29'h0, irq_en_ff};
            default: begin rd_mux = 32'h0; rd_hit = 1'b0; end
        endcase
    end
    assign nxt_rvalid = (s_axi_arvalid_i && arready_ff) || (rvalid_ff && !s_axi_rready_i);
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= `NAG_RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            arready_ff <= !nxt_rvalid;
            if (s_axi_arvalid_i && arready_ff) begin
                rdata_ff <= rd_mux;
                rresp_ff <= rd_hit ? `NAG_RESP_OKAY : `NAG_RESP_SLVERR;
            end
        end
    end

    // outputs straight from flops
    assign instr_ready_o = ready_ff;
    assign instr_done_o = done_ff;
    assign instr_skip_o = skip_ff;
    assign dm_addr_o = dm_addr_ff;
    assign dm_re_o = re_ff;
    assign dm_we_o = we_ff;
    assign dm_wdata_o = dm_wdata_ff;
    assign s_axi_awready_o = awready_ff;
    assign s_axi_wready_o = wready_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_arready_o = arready_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rdata_o = rdata_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign irq_o = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_accept;
        instr_valid_i && instr_ready_o;
    endsequence
    sequence s_done_at_six;
        !instr_done_o [*5] ##1 instr_done_o;
    endsequence
    chk_one_instruction: assert property (s_accept |=> s_done_at_six)
        else $error("instruction did not finish in six cycles");
    chk_greg_row_addr: assert property (s_accept |=> dm_re_o && dm_addr_o == {3'h0, $past(ptr_ff), $past(instr_col_i)})
        else $error("register read address wrong");
    chk_bank_limit: assert property (dm_re_o && state_ff == st_rd_r |-> dm_addr_o[10:8] == 3'h0)
        else $error("register bank beyond bank one");
    chk_index_modify: assert property (state_ff == st_latch && op_ff != op_indirect_fetch |=> dm_addr_o == $past(m_eff) && dm_re_o)
        else $error("operand address not modified");
    chk_indirect_col: assert property (state_ff == st_wb && op_ff == op_indirect_move |=> dm_we_o && dm_addr_o[3:0] == $past(tmp_a))
        else $error("indirect column not from register");
    chk_zero_flag: assert property (hw_upd && is_arith && !status_ff[`NAG_ST_CMP] |=> status_ff[`NAG_ST_Z] == ($past(add_res) == 4'h0))
        else $error("zero flag wrong in normal mode");
    chk_compare_mode: assert property (hw_upd && is_arith && status_ff[`NAG_ST_CMP] |=> !dm_we_o && (!status_ff[`NAG_ST_Z] || $past(status_ff[`NAG_ST_Z])))
        else $error("compare mode stored or set zero");
    chk_decimal_range: assert property (hw_upd && is_arith && status_ff[`NAG_ST_BCD] && !status_ff[`NAG_ST_CMP] && tmp_a <= 4'h9 && tmp_b <= 4'h9 |=> dm_we_o && dm_wdata_o <= 4'h9)
        else $error("decimal result out of range");
    chk_temp_hold: assert property (state_ff == st_exec |=> tmp_a == $past(tmp_a))
        else $error("temporary a changed before use");
endmodule : nag_alu_top

// >>> testbench/nag_mem_model.sv
// data memory partner: 2048 nibbles, read data one cycle after the read strobe
// assumes single-cycle strobes from the alu
`timescale 1ns/1ps
module nag_mem_model (
    input wire logic sys_clk_i,
    input wire logic [10:0] addr_i,
    input wire logic re_i,
    input wire logic we_i,
    input wire logic [3:0] wdata_i,
    output logic [3:0] rdata_o
);
    logic [3:0] mem [2048];
    // fixed preload, mirrored by the bench
    initial begin
        rdata_o = 4'h0;
        for (int i = 0; i < 2048; i++) mem[i] = 4'(i ^ (i >> 4) ^ (i >> 8));
    end
    // register row is plain memory; stale read data flips every cycle
    always @(posedge sys_clk_i) begin
        if (we_i) mem[addr_i] <= wdata_i;
        rdata_o <= re_i ? mem[addr_i] : ~rdata_o;
    end
endmodule : nag_mem_model

// >>> testbench/tb_nibble_alu_general_register.sv
// random instruction bench with a reference model of flags and memory
// assumes the alu top and the data memory model
`timescale 1ns/1ps
module tb_nibble_alu_general_register;
    import nag_pkg::*;
    logic sys_clk_i = 0, rst_i = 1, iv = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    nag_op_t op = op_add;
    logic [3:0] col = 0, imm = 0, rdat, wdat;
    logic [10:0] mem = 0, da;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, rdv;
    logic [1:0] br, rr, rrsp;
    logic rdy, dn, sk, re, we, awr, wrdy, bv, arr, rv, irq;
    int error_cnt = 0, checks_done = 0, ptr = 0, bcd = 0, cmp = 0, cy = 0, z = 0, ix = 0, idx = 0;
    int mq [2048];
    nag_alu_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_valid_i(iv), .instr_op_i(op), .instr_col_i(col),
        .instr_mem_i(mem), .instr_imm_i(imm), .instr_ready_o(rdy), .instr_done_o(dn), .instr_skip_o(sk),
        .dm_addr_o(da), .dm_re_o(re), .dm_we_o(we), .dm_wdata_o(wdat), .dm_rdata_i(rdat),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .irq_o(irq));
    nag_mem_model dmem (.sys_clk_i(sys_clk_i), .addr_i(da), .re_i(re), .we_i(we), .wdata_i(wdat), .rdata_o(rdat));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input int e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        do begin
            @(posedge sys_clk_i);
            if (awr === 1) awv <= 0;
            if (wrdy === 1) wv <= 0;
        end while (bv !== 1);
        bry <= 0;
        @(posedge sys_clk_i);
    endtask : wr
    task automatic rd_reg(input logic [7:0] a);
        ara <= a; arv <= 1; rry <= 1;
        do begin
            @(posedge sys_clk_i);
            if (arr === 1) arv <= 0;
        end while (rv !== 1);
        rdv = rd; rrsp = rr; rry <= 0;
    endtask : rd_reg
    // model the instruction, drive it, compare strobes and flags
    task automatic run(input nag_op_t o, input logic [3:0] c, input logic [10:0] m, input logic [3:0] n);
        int ra, r, mv, s, wa, wen, skp, ar, me;
        me = ix ? (m | idx) : m;
        ra = (ptr << 4) | c; r = mq[ra]; mv = mq[me]; wa = ra; wen = 1; skp = 0; s = 0;
        ar = o inside {op_add, op_add_with_carry, op_sub, op_subtract_with_borrow};
        case (o)
            op_add, op_add_with_carry: begin
                s = r + mv + (o == op_add_with_carry ? cy : 0);
                if (bcd && s > 9) s += 6;
                cy = s > 15;
            end
            op_sub, op_subtract_with_borrow: begin
                s = r - mv - (o == op_subtract_with_borrow ? cy : 0);
                cy = s < 0;
                if (bcd && s < 0) s -= 6;
            end
            op_and: s = r & mv;
            op_or: s = r | mv;
            op_xor: s = r ^ mv;
            op_load_register: s = mv;
            op_store_register: begin s = r; wa = me; end
            op_indirect_move: begin s = mv; wa = (me & 11'h7f0) | r; end
            op_rotate_right_carry: begin s = (cy << 3) | (r >> 1); cy = r & 1; end
            op_set_imm: begin s = n; wa = me; end
            op_indirect_fetch: begin s = mq[(me & 11'h7f0) | r]; wa = me; end
            op_skip_true: begin wen = 0; skp = ((mv & n) == n); end
            op_skip_false: begin wen = 0; skp = ((mv & n) == 0); end
            op_skip_ne: begin wen = 0; skp = (mv != n); end
            op_skip_ge: begin wen = 0; skp = (mv >= n); end
            op_skip_lt: begin wen = 0; skp = (mv < n); end
            default: begin wen = 0; skp = (mv == n); end
        endcase
        s = s & 15;
        if (ar) begin z = cmp ? (z && s == 0) : (s == 0); wen = !cmp; end
        if (wen) mq[wa] = s;
        iv <= 1; op <= o; col <= c; mem <= m; imm <= n;
        @(posedge sys_clk_i);
        iv <= 0;
        @(posedge sys_clk_i);
        #1;
        chk("reg addr", ra, da);
        for (int k = 0; k < 10 && dn !== 1; k++) begin @(posedge sys_clk_i); #1; end
        chk("done", 1, dn);
        chk("write", wen, we);
        chk("skip", skp, sk);
        if (wen) chk("waddr", wa, da);
        if (wen) chk("wdata", s, wdat);
        @(posedge sys_clk_i);
        rd_reg(8'h04);
        chk("status", (bcd << 4) | (cmp << 3) | (cy << 2) | (z << 1) | ix, rdv);
    endtask : run
    task automatic wrap_up();
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // clock and watchdog
    initial begin forever #5 sys_clk_i = ~sys_clk_i; end
    initial begin #500000; error_cnt++; wrap_up(); end
    // main sequence: four flag modes, random pointer and operands
    initial begin
        int p, m;
        void'($urandom(75096));
        for (int i = 0; i < 2048; i++) mq[i] = (i ^ (i >> 4) ^ (i >> 8)) & 15;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 0;
        repeat (3) @(posedge sys_clk_i);
        rd_reg(8'h04);
        chk("status rst", 0, rdv);
        wr(8'h18, 1);
        idx = $urandom & 2047;
        wr(8'h08, idx);
        for (int md = 0; md < 4; md++) begin
            bcd = md >> 1; cmp = md & 1; ix = $urandom & 1; cy = 0; z = 0;
            wr(8'h04, (bcd << 4) | (cmp << 3) | ix);
            repeat (14) begin
                p = $urandom & 127; ptr = p & 15; m = $urandom & 2047;
                wr(8'h00, p);
                rd_reg(8'h00);
                chk("pointer", ptr, rdv);
                if ($urandom % 4 == 0) m = (ptr << 4) | (m & 15);
                run(nag_op_t'($urandom % 19), 4'($urandom), 11'(m), ($urandom & 1) ? 4'(mq[m]) : 4'($urandom));
            end
        end
        chk("irq set", 1, irq);
        rd_reg(8'h10);
        chk("irq done", 1, rdv[0]);
        wr(8'h14, 7);
        repeat (2) @(posedge sys_clk_i);
        chk("irq clr", 0, irq);
        rd_reg(8'h40);
        chk("unmapped", 2, rrsp);
        chk("unmapped data", 0, rdv);
        wrap_up();
    end
endmodule : tb_nibble_alu_general_register
